/* design/cpt_clock_power_thermal.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Two-bit global power level for all channels: 00 per-channel, 10 low, 11 lowest.
// - Two-bit clock-out select, reset 10 (buffered input clock).
// - Automute enable mutes all outputs while unlocked; lock flag reads at bit 2.
// - Internal reference enable resets to 1; clearing lets outside drive common mode.
// - Clock source bit: 0 loop clock (reset), 1 direct input clock.
// - Continuous interval codes: 00 4 s, 01 0.5 s, 10 1 s, 11 2 s.
// - Conversion mode bit: 0 continuous, 1 one-shot; resets to one-shot.
// - In one-shot mode a written 0-then-1 on the trigger gives one conversion if the sensor is on; several during one conversion queue only one.
// - New temperature result visible within 120 ms of the trigger write.
// - Sensor power-down bit: 0 sensor runs, 1 sensor off.
// - Loop power-down bit: 0 normal, 1 loop off.
// - Regulator power-down bit: 0 normal, 1 regulator off.
// - Per-channel power-down bits: channels 1-8 at 0x03, 9-16 at 0x04.
// - Read-only temperature code, degrees equal code minus 60, resets to zero.
// - Soft reset restores all registers except 0x00 and 0x01; port keeps working.
module cpt_clock_power_thermal #(
	parameter int CONV_CYCLES = cpt_pkg::CPT_CONV_CYCLES,
	parameter int INTV_BASE = cpt_pkg::CPT_INTV_BASE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic loop_locked_async,
	input wire logic sensor_valid,
	input wire logic [7:0] sensor_code,
	output logic sensor_start,
	output cpt_pkg::cpt_ctrl_s ctrl
);
	import cpt_pkg::*;

	logic [7:0] clk_a_r;
	logic [7:0] clk_b_r;
	logic [7:0] pdn_th_r;
	logic [7:0] chan_lo_r;
	logic [7:0] chan_hi_r;
	logic [7:0] temp_r;
	logic lock_meta_r;
	logic lock_sync_r;
	logic oneshot_req_r;
	logic soft_rst;
	logic wr_a;
	logic wr_b;
	logic wr_c;
	logic wr_lo;
	logic wr_hi;
	logic res_valid;
	logic [7:0] res_code;
	logic [7:0] rd_nxt;

	function automatic logic hit(input logic en, input logic [7:0] addr,
		input logic [7:0] ofs);
		hit = en && (addr == ofs);
	endfunction

	assign soft_rst = clk_a_r[CPT_A_SOFT_RST];
	assign wr_a = hit(reg_wr, reg_addr, CPT_OFS_CLK_A);
	assign wr_b = hit(reg_wr, reg_addr, CPT_OFS_CLK_B);
	assign wr_c = hit(reg_wr, reg_addr, CPT_OFS_PDN_TH);
	assign wr_lo = hit(reg_wr, reg_addr, CPT_OFS_CHAN_LO);
	assign wr_hi = hit(reg_wr, reg_addr, CPT_OFS_CHAN_HI);

	// Clock control registers survive soft reset
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			clk_a_r <= CPT_CLK_A_RST;
		end else if (wr_a) begin
			clk_a_r <= reg_wdata;
		end
	end

	// Reserved power code is stored as written; its effect is left undefined
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			clk_b_r <= CPT_CLK_B_RST;
		end else if (wr_b) begin
			clk_b_r <= reg_wdata & CPT_CLK_B_WMASK;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pdn_th_r <= CPT_PDN_TH_RST;
		end else if (soft_rst) begin
			pdn_th_r <= CPT_PDN_TH_RST;
		end else if (wr_c) begin
			pdn_th_r <= reg_wdata & CPT_PDN_TH_WMASK;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			chan_lo_r <= CPT_CHAN_RST;
		end else if (soft_rst) begin
			chan_lo_r <= CPT_CHAN_RST;
		end else if (wr_lo) begin
			chan_lo_r <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			chan_hi_r <= CPT_CHAN_RST;
		end else if (soft_rst) begin
			chan_hi_r <= CPT_CHAN_RST;
		end else if (wr_hi) begin
			chan_hi_r <= reg_wdata;
		end
	end

	// Whole byte loads at once so a read never mixes two results
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			temp_r <= CPT_TEMP_RST;
		end else if (soft_rst) begin
			temp_r <= CPT_TEMP_RST;
		end else if (res_valid) begin
			temp_r <= res_code;
		end
	end

	// Lock comes from the analog loop, unrelated to core_clk
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lock_meta_r <= 1'b0;
			lock_sync_r <= 1'b0;
		end else begin
			lock_meta_r <= loop_locked_async;
			lock_sync_r <= lock_meta_r;
		end
	end

	// Only a write of 1 over a stored 0 counts; rewriting 1 does nothing
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			oneshot_req_r <= 1'b0;
		end else begin
			oneshot_req_r <= wr_c && !soft_rst && reg_wdata[CPT_C_ONE_SHOT] &&
				reg_wdata[CPT_C_TRIG] && !pdn_th_r[CPT_C_TRIG];
		end
	end

	cpt_thermal_seq #(
		.CONV_CYCLES(CONV_CYCLES),
		.INTV_BASE(INTV_BASE)
	) u_seq (
		.core_clk(core_clk),
		.rstn(rstn),
		.clear(soft_rst),
		.continuous(!pdn_th_r[CPT_C_ONE_SHOT]),
		.interval(cpt_intv_e'(pdn_th_r[CPT_C_RATE_LSB +: 2])),
		.sensor_off(pdn_th_r[CPT_C_SENS_PD]),
		.oneshot_req(oneshot_req_r),
		.sensor_valid(sensor_valid),
		.sensor_code(sensor_code),
		.sensor_start(sensor_start),
		.result_valid(res_valid),
		.result_code(res_code)
	);

	always_comb begin
		rd_nxt = 8'h00;
		case (reg_addr)
			CPT_OFS_CLK_A: rd_nxt = clk_a_r;
			CPT_OFS_CLK_B: begin
				rd_nxt = clk_b_r;
				rd_nxt[CPT_B_LOCK] = lock_sync_r;
			end
			CPT_OFS_PDN_TH: rd_nxt = pdn_th_r;
			CPT_OFS_CHAN_LO: rd_nxt = chan_lo_r;
			CPT_OFS_CHAN_HI: rd_nxt = chan_hi_r;
			CPT_OFS_TEMP: rd_nxt = temp_r;
			default: rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rd_nxt;
			end
		end
	end

	// Power-up is only forwarded; the host orders its writes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl.master_power_up <= 1'b0;
			ctrl.soft_reset_active <= 1'b0;
		end else begin
			ctrl.master_power_up <= clk_a_r[CPT_A_PWR_UP];
			ctrl.soft_reset_active <= soft_rst;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl.global_power_level <= CPT_PWR_PER_CHANNEL;
			ctrl.clock_out_select <= CPT_CLK_B_RST[CPT_B_CKO_LSB +: 2];
			ctrl.vref_enable <= CPT_CLK_B_RST[CPT_B_VREF];
			ctrl.direct_clock_select <= CPT_CLK_B_RST[CPT_B_CLK_SEL];
		end else begin
			ctrl.global_power_level <= cpt_pwr_e'(clk_b_r[CPT_B_PWR_LSB +: 2]);
			ctrl.clock_out_select <= clk_b_r[CPT_B_CKO_LSB +: 2];
			ctrl.vref_enable <= clk_b_r[CPT_B_VREF];
			ctrl.direct_clock_select <= clk_b_r[CPT_B_CLK_SEL];
		end
	end

	// Mute follows the synchronised lock, so it lags the loop by a few cycles
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl.automute_active <= 1'b0;
		end else begin
			ctrl.automute_active <= clk_b_r[CPT_B_AUTOMUTE] && !lock_sync_r;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl.sensor_power_down <= 1'b0;
			ctrl.loop_power_down <= 1'b0;
			ctrl.regulator_power_down <= 1'b0;
			ctrl.channel_power_down <= 16'h0000;
		end else begin
			ctrl.sensor_power_down <= pdn_th_r[CPT_C_SENS_PD];
			ctrl.loop_power_down <= pdn_th_r[CPT_C_LOOP_PD];
			ctrl.regulator_power_down <= pdn_th_r[CPT_C_REG_PD];
			ctrl.channel_power_down <= {chan_hi_r, chan_lo_r};
		end
	end
endmodule

/* inc/cpt_pkg.sv */
package cpt_pkg;
	localparam logic [7:0] CPT_OFS_CLK_A = 8'h00;
	localparam logic [7:0] CPT_OFS_CLK_B = 8'h01;
	localparam logic [7:0] CPT_OFS_PDN_TH = 8'h02;
	localparam logic [7:0] CPT_OFS_CHAN_LO = 8'h03;
	localparam logic [7:0] CPT_OFS_CHAN_HI = 8'h04;
	localparam logic [7:0] CPT_OFS_TEMP = 8'h05;

	localparam logic [7:0] CPT_CLK_A_RST = 8'h00;
	localparam logic [7:0] CPT_CLK_B_RST = 8'h2A;
	localparam logic [7:0] CPT_PDN_TH_RST = 8'hA0;
	localparam logic [7:0] CPT_CHAN_RST = 8'h00;
	localparam logic [7:0] CPT_TEMP_RST = 8'h00;

	// Lock flag and reserved bit are never stored
	localparam logic [7:0] CPT_CLK_B_WMASK = 8'hFB;
	localparam logic [7:0] CPT_PDN_TH_WMASK = 8'hF7;

	localparam int CPT_A_SOFT_RST = 3;
	localparam int CPT_A_PWR_UP = 0;
	localparam int CPT_B_PWR_LSB = 6;
	localparam int CPT_B_CKO_LSB = 4;
	localparam int CPT_B_AUTOMUTE = 3;
	localparam int CPT_B_LOCK = 2;
	localparam int CPT_B_VREF = 1;
	localparam int CPT_B_CLK_SEL = 0;
	localparam int CPT_C_RATE_LSB = 6;
	localparam int CPT_C_ONE_SHOT = 5;
	localparam int CPT_C_TRIG = 4;
	localparam int CPT_C_SENS_PD = 2;
	localparam int CPT_C_LOOP_PD = 1;
	localparam int CPT_C_REG_PD = 0;

	localparam int CPT_CLK_KHZ = 50000;
	localparam int CPT_CONV_TIME_MS = 120;
	localparam int CPT_CONV_CYCLES = CPT_CONV_TIME_MS * CPT_CLK_KHZ;
	localparam int CPT_CONV_MARGIN = 4;
	localparam int CPT_INTV_BASE_MS = 500;
	localparam int CPT_INTV_BASE_CYCLES = CPT_INTV_BASE_MS * CPT_CLK_KHZ;

	typedef enum logic [1:0] {
		CPT_PWR_PER_CHANNEL = 2'b00,
		CPT_PWR_RESERVED = 2'b01,
		CPT_PWR_LOW = 2'b10,
		CPT_PWR_LOWEST = 2'b11
	} cpt_pwr_e;

	typedef enum logic [1:0] {
		CPT_INTV_4S = 2'b00,
		CPT_INTV_0P5S = 2'b01,
		CPT_INTV_1S = 2'b10,
		CPT_INTV_2S = 2'b11
	} cpt_intv_e;

	typedef enum logic [0:0] {
		CPT_ST_IDLE = 1'b0,
		CPT_ST_CONVERT = 1'b1
	} cpt_state_e;

	typedef struct packed {
		cpt_pwr_e global_power_level;
		logic [1:0] clock_out_select;
		logic automute_active;
		logic vref_enable;
		logic direct_clock_select;
		logic master_power_up;
		logic soft_reset_active;
		logic sensor_power_down;
		logic loop_power_down;
		logic regulator_power_down;
		logic [15:0] channel_power_down;
	} cpt_ctrl_s;
endpackage

/* design/cpt_thermal_seq.sv */
`timescale 1ns/1ps
module cpt_thermal_seq #(
	parameter int CONV_CYCLES = cpt_pkg::CPT_CONV_CYCLES,
	parameter int INTV_BASE = cpt_pkg::CPT_INTV_BASE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clear,
	input wire logic continuous,
	input wire cpt_pkg::cpt_intv_e interval,
	input wire logic sensor_off,
	input wire logic oneshot_req,
	input wire logic sensor_valid,
	input wire logic [7:0] sensor_code,
	output logic sensor_start,
	output logic result_valid,
	output logic [7:0] result_code
);
	import cpt_pkg::*;

	cpt_state_e state_r;
	logic pend_r;
	logic [31:0] conv_cnt_r;
	logic [31:0] intv_cnt_r;
	logic [31:0] intv_limit;
	logic go;
	logic finish;

	function automatic logic [31:0] intv_cycles(input cpt_intv_e code);
		case (code)
			CPT_INTV_4S: intv_cycles = 32'(INTV_BASE * 8);
			CPT_INTV_0P5S: intv_cycles = 32'(INTV_BASE);
			CPT_INTV_1S: intv_cycles = 32'(INTV_BASE * 2);
			default: intv_cycles = 32'(INTV_BASE * 4);
		endcase
	endfunction

	assign intv_limit = intv_cycles(interval);
	assign go = (state_r == CPT_ST_IDLE) && !clear && !sensor_off &&
		(oneshot_req || pend_r || (continuous && intv_cnt_r >= intv_limit - 32'h1));
	// Deadline leaves margin for the request and readout register stages
	assign finish = (state_r == CPT_ST_CONVERT) &&
		(sensor_valid || conv_cnt_r == 32'(CONV_CYCLES - CPT_CONV_MARGIN));

	// A request during a running conversion is held, not lost
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pend_r <= 1'b0;
		end else if (oneshot_req && !clear) begin
			pend_r <= (state_r == CPT_ST_CONVERT);
		end else if (go || clear || sensor_off) begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			intv_cnt_r <= 32'h0;
		end else if (!continuous || clear || go || state_r != CPT_ST_IDLE) begin
			intv_cnt_r <= 32'h0;
		end else begin
			intv_cnt_r <= intv_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= CPT_ST_IDLE;
			conv_cnt_r <= 32'h0;
		end else begin
			case (state_r)
				CPT_ST_IDLE: begin
					conv_cnt_r <= 32'h0;
					if (go) begin
						state_r <= CPT_ST_CONVERT;
					end
				end
				CPT_ST_CONVERT: begin
					conv_cnt_r <= conv_cnt_r + 32'h1;
					if (clear || sensor_off || finish) begin
						state_r <= CPT_ST_IDLE;
					end
				end
				default: state_r <= CPT_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sensor_start <= 1'b0;
			result_valid <= 1'b0;
			result_code <= CPT_TEMP_RST;
		end else begin
			sensor_start <= go;
			result_valid <= finish && !clear && !sensor_off;
			if (finish) begin
				result_code <= sensor_code;
			end
		end
	end
endmodule

/* test/cpt_monitor.sv */
`timescale 1ns/1ps
module cpt_monitor (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rvalid,
	input wire logic loop_locked_async,
	input wire logic sensor_start,
	input wire cpt_pkg::cpt_ctrl_s ctrl
);
	import cpt_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire w01 = reg_wr && reg_addr == 8'h01;
	wire w03 = reg_wr && reg_addr == 8'h03;
	wire w00s = reg_wr && reg_addr == 8'h00 && reg_wdata[3];
	wire [5:0] wf = {reg_wdata[7:4], reg_wdata[1:0]};
	read_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read got no answer");
	read_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
		else $error("answer without read");
	start_pulse_a: assert property (sensor_start |=> !sensor_start)
		else $error("start longer than one cycle");
	// Soft reset written one cycle earlier is not yet seen on ctrl
	chan_store_a: assert property (w03 && !ctrl.soft_reset_active && !$past(w00s)
		|=> ##1 ctrl.channel_power_down[7:0] == $past(reg_wdata, 2))
		else $error("channel bits not stored");
	clk_fields_a: assert property (w01 |=> ##1 {ctrl.global_power_level,
		ctrl.clock_out_select, ctrl.vref_enable, ctrl.direct_clock_select} == $past(wf, 2))
		else $error("clock fields not stored");
	automute_lock_a: assert property (loop_locked_async [*4] |-> !ctrl.automute_active)
		else $error("muted while locked");
	sensor_off_a: assert property (ctrl.sensor_power_down && $past(ctrl.sensor_power_down)
		|-> !sensor_start)
		else $error("start while sensor off");
	soft_reset_a: assert property (ctrl.soft_reset_active |=> ctrl.channel_power_down == 16'h0000
		&& {ctrl.sensor_power_down, ctrl.loop_power_down, ctrl.regulator_power_down} == 3'h0)
		else $error("soft reset kept power bits");
endmodule

bind cpt_clock_power_thermal cpt_monitor u_cpt_monitor (
	.core_clk(core_clk),
	.rstn(rstn),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rvalid(reg_rvalid),
	.loop_locked_async(loop_locked_async),
	.sensor_start(sensor_start),
	.ctrl(ctrl)
);

/* test/cpt_sensor_model.sv */
`timescale 1ns/1ps
module cpt_sensor_model (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sensor_start,
	input wire logic [7:0] delay,
	input wire logic [7:0] code,
	output logic sensor_valid,
	output logic [7:0] sensor_code
);
	logic [7:0] cnt_r;
	// One valid pulse per start after delay cycles
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 8'h00;
			sensor_valid <= 1'b0;
			sensor_code <= 8'h00;
		end else begin
			cnt_r <= sensor_start ? delay : (cnt_r != 8'h00 ? cnt_r - 8'h01 : 8'h00);
			sensor_valid <= cnt_r == 8'h01;
			// Inverted off the valid cycle so a stale code is never mistaken for fresh
			sensor_code <= cnt_r == 8'h01 ? code : ~sensor_code;
		end
	end
endmodule

/* test/cpt_clock_power_thermal_tb.sv */
`timescale 1ns/1ps
module cpt_clock_power_thermal_tb;
	import cpt_pkg::*;
	logic core_clk, rstn, reg_wr, reg_rd, reg_rvalid, lock, s_valid, s_start;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, s_code, dly, code;
	logic [1:0] pw;
	cpt_ctrl_s ctrl;
	int n_fail = 0;
	int n_checks = 0;
	int n_st = 0;
	int cyc = 0;
	int i;
	int n0;
	cpt_clock_power_thermal #(.CONV_CYCLES(40), .INTV_BASE(50)) u_cpt_clock_power_thermal (
		.core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .loop_locked_async(lock), .sensor_valid(s_valid),
		.sensor_code(s_code), .sensor_start(s_start), .ctrl(ctrl));
	cpt_sensor_model u_cpt_sensor_model (.core_clk(core_clk), .rstn(rstn),
		.sensor_start(s_start), .delay(dly), .code(code), .sensor_valid(s_valid),
		.sensor_code(s_code));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (s_start === 1'b1) n_st++;
		if (cyc == 3000) begin
			n_fail++;
			wrap_up();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
		// Idle cycle so a strobe is never lowered and raised in one step
		@(negedge core_clk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk({reg_rvalid, reg_rdata}, {1'b1, e});
		@(negedge core_clk);
	endtask
	task wt(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task wrap_up();
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		lock = 1'b0;
		dly = 8'h0A;
		code = 8'h55;
		wt(8);
		rstn = 1'b1;
		wr(8'h00, 8'h01);
		rd(8'h01, 8'h2A);
		rd(8'h02, 8'hA0);
		rd(8'h04, 8'h00);
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h00);
		chk(ctrl, 28'h2D00000);
		for (i = 0; i < 4; i++) begin
			// Reserved level code skipped on purpose
			pw = (i == 1) ? 2'b00 : i[1:0];
			wr(8'h01, {pw, i[1:0], 2'b01, i[1], ~i[1]});
			rd(8'h01, {pw, i[1:0], 2'b00, i[1], ~i[1]});
			chk({ctrl.global_power_level, ctrl.clock_out_select, ctrl.automute_active,
				ctrl.vref_enable, ctrl.direct_clock_select},
				{pw, i[1:0], 1'b0, i[1], ~i[1]});
		end
		wr(8'h01, 8'h2A);
		lock = 1'b1;
		wt(4);
		rd(8'h01, 8'h2E);
		chk(ctrl.automute_active, 1'b0);
		lock = 1'b0;
		wt(4);
		chk(ctrl.automute_active, 1'b1);
		wr(8'h03, 8'h5A);
		wr(8'h04, 8'hA5);
		rd(8'h03, 8'h5A);
		chk(ctrl.channel_power_down, 16'hA55A);
		wr(8'h02, 8'h2F);
		rd(8'h02, 8'h27);
		chk({ctrl.sensor_power_down, ctrl.loop_power_down, ctrl.regulator_power_down},
			3'h7);
		wr(8'h05, 8'hFF);
		rd(8'h05, 8'h00);
		wr(8'h02, 8'h20);
		wr(8'h02, 8'h30);
		wt(38);
		rd(8'h05, 8'h55);
		wr(8'h02, 8'h30);
		wt(3);
		chk(n_st, 1);
		code = 8'hC8;
		wr(8'h02, 8'h20);
		wr(8'h02, 8'h30);
		wt(38);
		rd(8'h05, 8'hC8);
		chk(n_st, 2);
		wr(8'h02, 8'h24);
		wr(8'h02, 8'h34);
		wt(4);
		chk(n_st, 2);
		wr(8'h02, 8'h40);
		wt(300);
		chk(n_st >= 6 && n_st <= 8, 1'b1);
		wr(8'h02, 8'h24);
		wr(8'h02, 8'h80);
		n0 = n_st;
		wt(250);
		chk(n_st - n0, 2);
		wr(8'h02, 8'hA0);
		wr(8'h03, 8'hFF);
		wr(8'h01, 8'h13);
		wr(8'h00, 8'h09);
		wr(8'h03, 8'h77);
		wt(2);
		chk(ctrl.soft_reset_active, 1'b1);
		rd(8'h03, 8'h00);
		rd(8'h05, 8'h00);
		rd(8'h01, 8'h13);
		wr(8'h00, 8'h01);
		rd(8'h04, 8'h00);
		wrap_up();
	end
endmodule
